/* File: flash_seq_pkg.sv */
// Constants, register map and types for the flash row program sequencer
package flash_seq_pkg;
    // Register indices; odd ones cannot be byte addresses of aligned words
    localparam logic [11:0] IDX_CONTROL = 12'h260;
    localparam logic [11:0] IDX_ADDR_LOW = 12'h762;
    localparam logic [11:0] IDX_ADDR_HIGH = 12'h764;
    localparam logic [11:0] IDX_UNLOCK_KEY = 12'h766;
    // Byte addresses, four times the index, one 32-bit word each
    localparam logic [15:0] OFF_CONTROL = {2'b00, IDX_CONTROL, 2'b00};
    localparam logic [15:0] OFF_ADDR_LOW = {2'b00, IDX_ADDR_LOW, 2'b00};
    localparam logic [15:0] OFF_ADDR_HIGH = {2'b00, IDX_ADDR_HIGH, 2'b00};
    localparam logic [15:0] OFF_UNLOCK_KEY = {2'b00, IDX_UNLOCK_KEY, 2'b00};
    // Control register fields
    localparam int GO_BIT = 15;
    localparam int ENABLE_BIT = 14;
    localparam int FAULT_BIT = 13;
    localparam int TIMING_BIT = 8;
    localparam int OPSEL_LSB = 0;
    localparam int OPSEL_W = 7;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK = 16'h417F;
    localparam logic [15:0] KEY_RESET = 16'h0000;
    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Operation codes for a whole row, erase and program
    localparam logic [6:0] OP_ROW_ERASE = 7'h41;
    localparam logic [6:0] OP_ROW_PROGRAM = 7'h01;
    // Row geometry
    localparam int ROW_WORDS = 32;
    localparam int ROW_IDX_W = 5;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int OP_TIME_US = 2000;
    localparam int OP_CYCLES = (CLK_HZ / 1000000) * OP_TIME_US;
    localparam int CNT_W = 16;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } seq_state_t;
endpackage : flash_seq_pkg

/* File: flash_unlock_tracker.sv */
// Tracks the ordered two-write unlock key sequence
`timescale 1ns/1ps
module flash_unlock_tracker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Key writes and other register writes
    input wire logic key_write,
    input wire logic [7:0] key_value,
    input wire logic other_write,
    input wire logic consume,
    // Armed after 0x55 then 0xAA
    output logic armed
);
    logic first_seen;

    // Any write breaks the sequence; only adjacent key pair arms
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_seen <= 1'b0;
            armed <= 1'b0;
        end
        else if (key_write)
        begin
            first_seen <= (key_value == flash_seq_pkg::KEY_FIRST);
            armed <= first_seen && (key_value == flash_seq_pkg::KEY_SECOND);
        end
        else if (other_write || consume)
        begin
            // Go write consumes arming, so the pair must precede every go
            first_seen <= 1'b0;
            armed <= 1'b0;
        end
    end

    // Arming only follows a key write of 0xAA
    unlock_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(armed) |-> $past(key_write) && $past(key_value) == flash_seq_pkg::KEY_SECOND)
        else $error("unlock armed without second key");
endmodule : flash_unlock_tracker

/* File: flash_op_timer.sv */
// Counts out the nominal duration of one flash operation
`timescale 1ns/1ps
module flash_op_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    output logic expired
);
    localparam logic [15:0] LAST = 16'(flash_seq_pkg::OP_CYCLES - 1);
    logic [15:0] count;
    logic running;

    // Free count from start until the last cycle of the window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 16'h0000;
            running <= 1'b0;
        end
        else if (start)
        begin
            count <= 16'h0000;
            running <= 1'b1;
        end
        else if (running)
        begin
            if (count == LAST)
                running <= 1'b0;
            count <= count + 16'h0001;
        end
    end

    assign expired = running && (count == LAST);
endmodule : flash_op_timer

/* File: flash_row_program_sequencer.sv */
// Flash row erase/program sequencer with APB register access
`timescale 1ns/1ps
module flash_row_program_sequencer (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor stall
    output logic cpu_stall,
    // Flash array row operation
    output logic flash_erase,
    output logic flash_program,
    output logic [23:0] flash_row_addr,
    input wire logic flash_row_done
);
    logic [15:0] control;
    logic [15:0] addr_low;
    logic [7:0] addr_high;
    logic [15:0] stall_cycles;
    logic armed;
    logic expired;
    logic start_op;
    logic go_req;
    logic [6:0] op_sel;
    flash_seq_pkg::seq_state_t state;
    flash_seq_pkg::seq_state_t next_state;

    // Address decode used for both write and read paths
    function automatic logic [2:0] decode(input logic [15:0] a);
        case (a)
            flash_seq_pkg::OFF_CONTROL: decode = 3'h1;
            flash_seq_pkg::OFF_ADDR_LOW: decode = 3'h2;
            flash_seq_pkg::OFF_ADDR_HIGH: decode = 3'h3;
            flash_seq_pkg::OFF_UNLOCK_KEY: decode = 3'h4;
            default: decode = 3'h0;
        endcase
    endfunction : decode

    logic wr_access;
    logic [2:0] sel;
    logic wr_control;
    logic wr_addr_low;
    logic wr_addr_high;
    logic wr_key;
    assign wr_access = psel && penable && pwrite;
    assign sel = decode(paddr);

    // One write strobe per register, all taken in the access phase
    assign wr_control = wr_access && (sel == 3'h1);
    assign wr_addr_low = wr_access && (sel == 3'h2);
    assign wr_addr_high = wr_access && (sel == 3'h3);
    assign wr_key = wr_access && (sel == 3'h4);

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && (sel == 3'h0);

    // Go request: write with go bit set while idle
    assign go_req = wr_control && pwdata[flash_seq_pkg::GO_BIT]
        && (state == flash_seq_pkg::ST_IDLE);
    assign op_sel = pwdata[flash_seq_pkg::OPSEL_LSB +: flash_seq_pkg::OPSEL_W];
    // Launch only when unlocked and enabled, with a row-wide opcode
    assign start_op = go_req && armed && pwdata[flash_seq_pkg::ENABLE_BIT]
        && ((op_sel == flash_seq_pkg::OP_ROW_ERASE)
        || (op_sel == flash_seq_pkg::OP_ROW_PROGRAM));

    flash_unlock_tracker u_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .key_write(wr_key),
        .key_value(pwdata[7:0]),
        .other_write(wr_access && !wr_key && !go_req),
        .consume(go_req),
        .armed(armed)
    );

    flash_op_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_op),
        .expired(expired)
    );

    // Sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            flash_seq_pkg::ST_IDLE:
                if (start_op)
                    next_state = flash_seq_pkg::ST_RUN;
            flash_seq_pkg::ST_RUN:
                if (expired)
                    next_state = flash_seq_pkg::ST_DONE;
            flash_seq_pkg::ST_DONE:
                next_state = flash_seq_pkg::ST_IDLE;
            default:
                next_state = flash_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= flash_seq_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // Control register; go bit stays set only for a launched operation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control <= flash_seq_pkg::CONTROL_RESET;
        else if (state == flash_seq_pkg::ST_DONE)
            control[flash_seq_pkg::GO_BIT] <= 1'b0;
        else if (wr_control && (state == flash_seq_pkg::ST_IDLE))
        begin
            // Writable fields; fault bit is only cleared by software
            control <= (pwdata[15:0] & flash_seq_pkg::CONTROL_WMASK)
                | (control[flash_seq_pkg::FAULT_BIT] && pwdata[flash_seq_pkg::FAULT_BIT]
                ? 16'h2000 : 16'h0000);
            control[flash_seq_pkg::GO_BIT] <= start_op;
            if (go_req && !start_op)
                control[flash_seq_pkg::FAULT_BIT] <= 1'b1; // Refused go flagged
        end
    end

    // Split target address registers, locked while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_low <= 16'h0000;
            addr_high <= 8'h00;
        end
        else if (state == flash_seq_pkg::ST_IDLE)
        begin
            if (wr_addr_low)
                addr_low <= pwdata[15:0];
            if (wr_addr_high)
                addr_high <= pwdata[7:0];
        end
    end

    // Read data registered in the setup phase, ready for the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            case (sel)
                3'h1: prdata <= {16'h0000, control};
                3'h2: prdata <= {16'h0000, addr_low};
                3'h3: prdata <= {24'h000000, addr_high};
                // Key register reads back zero so keys cannot be snooped
                3'h4: prdata <= 32'h00000000;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Stall the processor for the whole operation
    assign cpu_stall = (state == flash_seq_pkg::ST_RUN);

    // Operation kind from flops, loaded at launch and dropped at expiry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flash_erase <= 1'b0;
            flash_program <= 1'b0;
        end
        else if (start_op)
        begin
            flash_erase <= (op_sel == flash_seq_pkg::OP_ROW_ERASE);
            flash_program <= (op_sel == flash_seq_pkg::OP_ROW_PROGRAM);
        end
        else if (expired)
        begin
            flash_erase <= 1'b0;
            flash_program <= 1'b0;
        end
    end

    // Row latched at launch; low six address bits cleared for row alignment
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flash_row_addr <= 24'h000000;
        else if (start_op)
            flash_row_addr <= {addr_high, addr_low[15:6], 6'h00};
    end

    // Helper count of stalled cycles, so the length is checked, not assumed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stall_cycles <= 16'h0000;
        else if (cpu_stall)
            stall_cycles <= stall_cycles + 16'h0001;
        else
            stall_cycles <= 16'h0000;
    end

    logic unused_done;
    assign unused_done = flash_row_done;

    // Stall lasts at least 8 cycles once it rises
    stall_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cpu_stall) |-> cpu_stall [*8])
        else $error("stall ended early");
    // Go clears the cycle after the run ends
    go_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(cpu_stall) |=> !control[flash_seq_pkg::GO_BIT])
        else $error("go bit not cleared");
    // Nothing starts unless armed
    start_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cpu_stall) |-> $past(armed))
        else $error("operation started while locked");

    // Stall ends after exactly the fixed operation count
    stall_total_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(cpu_stall) |-> stall_cycles == 16'(flash_seq_pkg::OP_CYCLES))
        else $error("stall length differs from operation time");

    // Stall never outlives the operation window
    stall_span_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_stall |-> stall_cycles < 16'(flash_seq_pkg::OP_CYCLES))
        else $error("stall longer than operation time");

    // Target address frozen while the array works
    addr_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_stall |=> $stable(addr_low) && $stable(addr_high))
        else $error("address changed during operation");

    // Exactly one row operation drives the array while stalled
    op_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_stall |-> (flash_erase != flash_program))
        else $error("no single row operation during stall");

    // Array left alone outside the stall
    idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cpu_stall |-> !flash_erase && !flash_program)
        else $error("array operation outside stall");

    // Opcode cannot change under a running operation
    opsel_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_stall |=> $stable(control[6:0]))
        else $error("opcode changed during operation");

    // Row seen by the array holds for the whole operation
    row_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_stall |=> $stable(flash_row_addr))
        else $error("row address changed during operation");

    // Launch enters the stall with the go bit set
    launch_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_op |=> cpu_stall && control[flash_seq_pkg::GO_BIT])
        else $error("launch did not start operation");

    // Go bit stands through the stall
    go_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_stall |-> control[flash_seq_pkg::GO_BIT])
        else $error("go bit low during operation");

    // Completion returns to idle with go cleared
    done_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == flash_seq_pkg::ST_DONE) |=> (state == flash_seq_pkg::ST_IDLE)
        && !control[flash_seq_pkg::GO_BIT])
        else $error("operation end not clean");

    // Go bit reads low whenever idle
    idle_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == flash_seq_pkg::ST_IDLE) |-> !control[flash_seq_pkg::GO_BIT])
        else $error("go bit set while idle");

    // Refused go raises the fault and starts nothing
    refuse_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_req && !start_op |=> control[flash_seq_pkg::FAULT_BIT] && !cpu_stall)
        else $error("refused go not flagged");

    // Fault stays until software writes the control register
    fault_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        control[flash_seq_pkg::FAULT_BIT] && !wr_control |=> control[flash_seq_pkg::FAULT_BIT])
        else $error("fault flag lost");

    // Every go uses up the key pair
    key_consume_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_req |=> !armed)
        else $error("key pair survived a go");
endmodule : flash_row_program_sequencer

/* File: tb_top.sv */
// Self-checking bench for the flash row program sequencer
`timescale 1ns/1ps
module tb_top;
    // Design connections
    logic pclk, presetn, psel, penable, pwrite, flash_row_done;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, slv, cpu_stall, flash_erase, flash_program;
    logic [23:0] flash_row_addr;
    int n_fail, n_compared, k;

    flash_row_program_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
        .flash_program(flash_program), .flash_row_addr(flash_row_addr),
        .flash_row_done(flash_row_done));

    // Free-running 25 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1)
        begin
            n_fail++;
            end_of_test();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [15:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rchk

    // Key pair, then the control write carrying the go bit
    task launch(input logic [31:0] ctl);
        apb(1'b1, flash_seq_pkg::OFF_UNLOCK_KEY, 32'h0000_0055);
        apb(1'b1, flash_seq_pkg::OFF_UNLOCK_KEY, 32'h0000_00AA);
        apb(1'b1, flash_seq_pkg::OFF_CONTROL, ctl);
        #1;
    endtask : launch

    initial
    begin
        {psel, penable, pwrite, flash_row_done} = 4'h0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped access, address split
        rchk(flash_seq_pkg::OFF_CONTROL, 32'h0000_0000, "control reset");
        rchk(flash_seq_pkg::OFF_UNLOCK_KEY, 32'h0000_0000, "key reset");
        apb(1'b0, 16'h0100, 32'h0000_0000);
        chk("unmapped slverr", 32'h1, {31'h0, slv});
        apb(1'b1, flash_seq_pkg::OFF_ADDR_LOW, 32'h0000_1234);
        apb(1'b1, flash_seq_pkg::OFF_ADDR_HIGH, 32'h0000_FFAB);
        rchk(flash_seq_pkg::OFF_ADDR_LOW, 32'h0000_1234, "addr low");
        rchk(flash_seq_pkg::OFF_ADDR_HIGH, 32'h0000_00AB, "addr high");
        $display("test registers done");
        // Refused go: no keys, key pair broken, enable clear
        apb(1'b1, flash_seq_pkg::OFF_CONTROL, 32'h0000_C041);
        rchk(flash_seq_pkg::OFF_CONTROL, 32'h0000_6041, "go without keys");
        apb(1'b1, flash_seq_pkg::OFF_UNLOCK_KEY, 32'h0000_0055);
        apb(1'b1, flash_seq_pkg::OFF_UNLOCK_KEY, 32'h0000_00AA);
        apb(1'b1, flash_seq_pkg::OFF_ADDR_LOW, 32'h0000_1234);
        apb(1'b1, flash_seq_pkg::OFF_CONTROL, 32'h0000_C041);
        #1;
        chk("stall broken keys", 32'h0, {31'h0, cpu_stall});
        apb(1'b1, flash_seq_pkg::OFF_UNLOCK_KEY, 32'h0000_00AA);
        apb(1'b1, flash_seq_pkg::OFF_UNLOCK_KEY, 32'h0000_0055);
        apb(1'b1, flash_seq_pkg::OFF_CONTROL, 32'h0000_C041);
        #1;
        chk("stall keys reversed", 32'h0, {31'h0, cpu_stall});
        launch(32'h0000_C040);
        chk("stall bad opcode", 32'h0, {31'h0, cpu_stall});
        rchk(flash_seq_pkg::OFF_CONTROL, 32'h0000_6040, "bad opcode fault");
        launch(32'h0000_8041);
        chk("stall no enable", 32'h0, {31'h0, cpu_stall});
        rchk(flash_seq_pkg::OFF_CONTROL, 32'h0000_2041, "fault flag");
        apb(1'b1, flash_seq_pkg::OFF_CONTROL, 32'h0000_0000);
        rchk(flash_seq_pkg::OFF_CONTROL, 32'h0000_0000, "fault cleared");
        $display("test refused go done");
        // Program launch, write ignored while stalled, reset mid-run
        launch(32'h0000_C001);
        chk("program stall", 32'h3, {30'h0, cpu_stall, flash_program});
        chk("row address", 32'h00AB_1200, {8'h00, flash_row_addr});
        apb(1'b1, flash_seq_pkg::OFF_ADDR_LOW, 32'h0000_0000);
        rchk(flash_seq_pkg::OFF_ADDR_LOW, 32'h0000_1234, "write in stall");
        rchk(flash_seq_pkg::OFF_CONTROL, 32'h0000_C001, "go while busy");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("stall in reset", 32'h0, {31'h0, cpu_stall});
        presetn <= 1'b1;
        $display("test program launch done");
        // Full erase: stall length, then go bit self-clears
        apb(1'b1, flash_seq_pkg::OFF_ADDR_HIGH, 32'h0000_0012);
        apb(1'b1, flash_seq_pkg::OFF_ADDR_LOW, 32'h0000_ABFF);
        launch(32'h0000_C041);
        chk("erase stall", 32'h5, {29'h0, cpu_stall, flash_program, flash_erase});
        chk("erase row", 32'h0012_ABC0, {8'h00, flash_row_addr});
        k = 0;
        while (cpu_stall === 1'b1 && k < 60000)
        begin
            @(posedge pclk);
            #1;
            k++;
        end
        chk("stall cycles", flash_seq_pkg::OP_CYCLES, k);
        rchk(flash_seq_pkg::OFF_CONTROL, 32'h0000_4041, "go cleared");
        $display("test erase done");
        end_of_test();
    end
endmodule : tb_top
